// ### cascade_pkg.sv
// package of constants and types for the pump group coordinator
package cascade_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int MAX_PUMPS = 8;
  localparam logic [2:0] MASTER_ADDR = 3'h0;
  localparam logic [2:0] FIRST_SLAVE_ADDR = 3'h1;
  localparam logic [2:0] LAST_SLAVE_ADDR = 3'h7;
  // times in their own units
  localparam int HALT_SEC = 30;
  localparam int SHORT_SWAP_MIN = 5;
  localparam int SEC_PER_MIN = 60;
  localparam int SEC_PER_HOUR = 3600;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam logic [15:0] HALT_SECS = 16'(HALT_SEC);
  localparam logic [15:0] SHORT_SWAP_SECS = 16'(SHORT_SWAP_MIN * SEC_PER_MIN);
  localparam logic [15:0] HOUR_SECS = 16'(SEC_PER_HOUR);
  // avalon register byte addresses
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_PERIOD = 6'h04;
  localparam logic [5:0] REG_STATUS = 6'h08;
  localparam logic [5:0] REG_IRQ_STAT = 6'h0C;
  localparam logic [5:0] REG_IRQ_CLR = 6'h10;
  localparam logic [5:0] REG_IRQ_EN = 6'h14;
  localparam logic [5:0] REG_PARAM = 6'h18;
  localparam logic [5:0] REG_PEER = 6'h1C;
  // control register fields
  localparam int CTRL_MODE = 0;
  localparam int CTRL_ROT = 1;
  localparam int CTRL_AUTORST = 2;
  localparam int CTRL_MENU = 3;
  localparam int CTRL_START = 4;
  localparam int CTRL_STOP = 5;
  localparam int CTRL_KEY = 6;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int CTRL_EXCL_LSB = 16;
  // interrupt events
  localparam int IRQ_W = 4;
  localparam int EV_LINK_LOST = 0;
  localparam int EV_ADDR_CONF = 1;
  localparam int EV_SWAP = 2;
  localparam int EV_COPY = 3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN = 3'b001,
    ST_LOST = 3'b010,
    ST_CONFLICT = 3'b011,
    ST_MENU = 3'b100
  } group_state_t;
endpackage : cascade_pkg

// ### sec_tick.sv
// one-second enable pulse divider
`timescale 1ns/10ps
module sec_tick #(
  parameter int CYCLES = 20_000_000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // output pulse
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tick_state_t;
  tick_state_t s_reg, s_next;
  // count up and pulse at wrap
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == 32'(CYCLES - 1)) begin
      s_next.cnt = 32'h0000_0000;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 32'h0000_0001;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign tick = s_reg.tick;
endmodule : sec_tick

// ### pin_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // pins in, filtered out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_state_t;
  sync_state_t s_reg, s_next;
  // per bit update once stages two and three agree
  always_comb begin
    s_next = s_reg;
    s_next.s1 = pin_in;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (s_reg.s2[i] == s_reg.s3[i]) begin
        s_next.q[i] = s_reg.s3[i];
      end
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign pin_out = s_reg.q;
endmodule : pin_sync

// ### cascade_coordinator.sv
// group coordinator for a cascade of pump inverters
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
module cascade_coordinator
  import cascade_pkg::*;
#(
  parameter int SEC_CYC = cascade_pkg::SEC_CYCLES,
  parameter int NP = cascade_pkg::MAX_PUMPS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // link view of the other units (pins)
  input wire logic [NP-1:0] peer_alive,
  input wire logic [NP-1:0] peer_at_max,
  input wire logic power_surplus,
  input wire logic power_short,
  input wire logic orig_master_back,
  // outputs
  output logic [NP-1:0] pump_run,
  output logic link_active,
  output logic param_copy,
  output logic link_lost_alarm,
  output logic address_conflict_alarm,
  output logic [2:0] node_addr,
  output logic irq
);
  import cascade_pkg::*;

  typedef struct packed {
    logic mode;
    logic rot;
    logic autorst;
    logic menu;
    logic [2:0] cfg_addr;
    logic [NP-1:0] excl;
    logic [15:0] period;
    logic [31:0] param;
    group_state_t st;
    logic [NP-1:0] run;
    logic [2:0] lead;
    logic [2:0] addr;
    logic promoted;
    logic [15:0] halt_s;
    logic [15:0] run_s;
    logic [15:0] run_h;
    logic copy;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [31:0] rdata;
    logic ack;
  } coord_state_t;
  coord_state_t s_reg, s_next;

  logic tick;
  logic [NP-1:0] alive_q, atmax_q;
  logic [2:0] misc_q;
  logic wr_hit, rd_hit, keypad, start_cmd, stop_cmd;
  logic [NP-1:0] elig, all_max;
  logic [IRQ_W-1:0] ev;

  // one-second enable
  sec_tick #(.CYCLES(SEC_CYC)) u_tick (
    .core_clk(core_clk),
    .resetn(resetn),
    .tick(tick)
  );

  // synchronise link and sensor pins
  pin_sync #(.W(2 * NP + 3)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin_in({peer_alive, peer_at_max, power_surplus, power_short, orig_master_back}),
    .pin_out({alive_q, atmax_q, misc_q})
  );

  // bus strobes, one wait cycle per access
  assign wr_hit = avs_write && s_reg.ack; // write lands where waitrequest is low
  assign rd_hit = avs_read && !s_reg.ack;
  assign avs_waitrequest = (avs_read || avs_write) && !s_reg.ack;
  assign avs_readdata = s_reg.rdata;
  assign keypad = wr_hit && (avs_address == REG_CTRL) && avs_writedata[CTRL_KEY];
  // commands only honoured at the master address
  assign start_cmd = wr_hit && (avs_address == REG_CTRL) && avs_writedata[CTRL_START]
    && (s_reg.addr == MASTER_ADDR);
  assign stop_cmd = wr_hit && (avs_address == REG_CTRL) && avs_writedata[CTRL_STOP]
    && (s_reg.addr == MASTER_ADDR);

  // eligible pumps: alive and present, failed units dropped
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      elig[i] = alive_q[i];
      all_max[i] = !s_reg.run[i] || atmax_q[i];
    end
  end

  // next state
  always_comb begin
    logic [2:0] idx;
    logic found;
    logic [15:0] limit;
    idx = 3'h0;
    found = 1'b0;
    limit = 16'h0000;
    s_next = s_reg;
    s_next.copy = 1'b0;
    ev = '0;
    s_next.ack = (avs_read || avs_write) && !s_reg.ack;
    // register writes
    if (wr_hit) begin
      case (avs_address)
        REG_CTRL: begin
          s_next.mode = avs_writedata[CTRL_MODE];
          s_next.rot = avs_writedata[CTRL_ROT];
          s_next.autorst = avs_writedata[CTRL_AUTORST];
          s_next.menu = avs_writedata[CTRL_MENU];
          s_next.cfg_addr = avs_writedata[CTRL_ADDR_LSB +: 3];
          s_next.excl = avs_writedata[CTRL_EXCL_LSB +: NP];
        end
        REG_PERIOD: s_next.period = avs_writedata[15:0];
        REG_PARAM: s_next.param = avs_writedata;
        REG_IRQ_EN: s_next.irq_en = avs_writedata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (!s_reg.promoted && s_reg.st == ST_IDLE) begin
      s_next.addr = s_next.cfg_addr;
    end
    // read mux
    if (rd_hit) begin
      case (avs_address)
        REG_CTRL: s_next.rdata = 32'({s_reg.excl, 5'h00, s_reg.cfg_addr, 4'h0, s_reg.menu,
          s_reg.autorst, s_reg.rot, s_reg.mode});
        REG_PERIOD: s_next.rdata = {16'h0000, s_reg.period};
        REG_STATUS: s_next.rdata = 32'({s_reg.run, 2'h0, s_reg.lead, 1'b0, s_reg.addr,
          s_reg.promoted, s_reg.st});
        REG_IRQ_STAT: s_next.rdata = 32'(s_reg.irq_stat);
        REG_IRQ_EN: s_next.rdata = 32'(s_reg.irq_en);
        REG_PARAM: s_next.rdata = s_reg.param;
        REG_PEER: s_next.rdata = {16'h0000, atmax_q, alive_q};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
    // group state machine
    case (s_reg.st)
      ST_IDLE: begin
        s_next.run = '0;
        if (s_reg.menu) begin
          s_next.st = ST_MENU;
        end else if (s_reg.mode && s_reg.addr == FIRST_SLAVE_ADDR && !alive_q[0]
            && !s_reg.promoted && s_reg.autorst) begin
          // an idle slave one still watches for master loss
          s_next.st = ST_LOST;
          s_next.halt_s = '0;
        end else if (start_cmd && s_reg.mode) begin
          // run the first eligible pump from the lead position; lead itself is not changed
          for (int k = 0; k < NP; k++) begin
            if (!found && elig[3'(s_reg.lead + 3'(k))]) begin
              idx = 3'(s_reg.lead + 3'(k));
              found = 1'b1;
            end
          end
          if (found) begin
            s_next.run[idx] = 1'b1;
          end
          s_next.st = ST_RUN;
          s_next.run_s = '0;
          s_next.run_h = '0;
        end
      end
      ST_RUN: begin
        s_next.run = s_reg.run & elig;
        if (s_reg.menu) begin
          s_next.st = ST_MENU;
          s_next.run = '0;
        end else if (stop_cmd) begin
          s_next.st = ST_IDLE;
        end else if (s_reg.addr == FIRST_SLAVE_ADDR && !alive_q[0] && s_reg.promoted == 1'b0
            && s_reg.autorst) begin
          s_next.st = ST_LOST;
          s_next.halt_s = '0;
          s_next.run = '0;
        end else if (s_reg.promoted && misc_q[0] && s_reg.autorst) begin
          s_next.st = ST_CONFLICT;
          s_next.halt_s = '0;
          s_next.run = '0;
        end else if (misc_q[2] && (&all_max)) begin
          // start next pump in priority order
          for (int k = 0; k < NP; k++) begin
            if (!found && elig[3'(s_reg.lead + 3'(k))] && !s_reg.run[3'(s_reg.lead + 3'(k))]) begin
              idx = 3'(s_reg.lead + 3'(k));
              found = 1'b1;
            end
          end
          if (found && tick) begin
            s_next.run[idx] = 1'b1;
          end
        end else if (misc_q[1] && tick) begin
          // stop the last running pump in priority order after the lead
          for (int k = 0; k < NP; k++) begin
            if (s_reg.run[3'(s_reg.lead + 3'(k))] && k != 0) begin
              idx = 3'(s_reg.lead + 3'(k));
              found = 1'b1;
            end
          end
          if (found) begin
            s_next.run[idx] = 1'b0;
          end else begin
            s_next.run = '0;
          end
        end
        // duty rotation timer
        limit = (s_reg.period == 16'h0000) ? SHORT_SWAP_SECS : HOUR_SECS;
        if (s_reg.rot && tick) begin
          s_next.run_s = s_reg.run_s + 16'h0001;
          if (s_next.run_s >= limit) begin
            s_next.run_s = '0;
            s_next.run_h = s_reg.run_h + 16'h0001;
            if (s_reg.period == 16'h0000 || s_next.run_h >= s_reg.period) begin
              s_next.run_h = '0;
              found = 1'b0;
              // advance lead among participating units
              for (int k = 1; k <= NP; k++) begin
                if (!found && elig[3'(s_reg.lead + 3'(k))]
                    && !s_reg.excl[3'(s_reg.lead + 3'(k))]) begin
                  idx = 3'(s_reg.lead + 3'(k));
                  found = 1'b1;
                end
              end
              if (found) begin
                s_next.lead = idx;
                s_next.run[s_reg.lead] = 1'b0;
                s_next.run[idx] = 1'b1;
              end
              ev[EV_SWAP] = 1'b1;
            end
          end
        end
      end
      ST_LOST, ST_CONFLICT: begin
        s_next.run = '0;
        if (keypad) begin
          s_next.st = ST_IDLE;
        end else if (tick) begin
          s_next.halt_s = s_reg.halt_s + 16'h0001;
          if (s_next.halt_s >= HALT_SECS) begin
            s_next.st = ST_RUN;
            s_next.promoted = (s_reg.st == ST_LOST);
            s_next.addr = (s_reg.st == ST_LOST) ? MASTER_ADDR : FIRST_SLAVE_ADDR;
          end
        end
      end
      ST_MENU: begin
        s_next.run = '0;
        if (!s_reg.menu) begin
          s_next.st = ST_IDLE;
          s_next.copy = 1'b1;
          ev[EV_COPY] = 1'b1;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
    ev[EV_LINK_LOST] = (s_next.st == ST_LOST || s_next.st == ST_MENU)
      && !(s_reg.st == ST_LOST || s_reg.st == ST_MENU);
    ev[EV_ADDR_CONF] = (s_next.st == ST_CONFLICT) && (s_reg.st != ST_CONFLICT);
    // sticky status, set wins over clear
    if (wr_hit && avs_address == REG_IRQ_CLR) begin
      s_next.irq_stat = s_reg.irq_stat & ~avs_writedata[IRQ_W-1:0];
    end
    s_next.irq_stat = s_next.irq_stat | ev;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs
  assign pump_run = s_reg.run;
  assign link_active = !(s_reg.st == ST_MENU || s_reg.st == ST_LOST);
  assign param_copy = s_reg.copy;
  assign link_lost_alarm = (s_reg.st == ST_MENU) || (s_reg.st == ST_LOST);
  assign address_conflict_alarm = (s_reg.st == ST_CONFLICT);
  assign node_addr = s_reg.addr;
  assign irq = |(s_reg.irq_stat & s_reg.irq_en);

  // assertions
  a_menu_alarm: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_reg.st == ST_MENU) |-> (link_lost_alarm && !link_active))
    else $error("menu open without link alarm");
  a_menu_copy: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_reg.st == ST_MENU && !s_reg.menu) |=> param_copy)
    else $error("no parameter copy after menu exit");
  a_halt_stop: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_reg.st == ST_LOST || s_reg.st == ST_CONFLICT) |-> (pump_run == '0))
    else $error("pumps run during changeover halt");
  a_conf_alarm: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_reg.st == ST_CONFLICT) |-> address_conflict_alarm)
    else $error("conflict without address alarm");
  a_key_abort: assert property (@(posedge core_clk) disable iff (!resetn)
    ((s_reg.st == ST_LOST) && keypad) |=> (s_reg.st == ST_IDLE))
    else $error("keypad did not abort changeover");
  a_no_autorst: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_reg.st != ST_LOST && s_next.st == ST_LOST) |-> s_reg.autorst)
    else $error("changeover without automatic restart");
  a_start_one: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_reg.st == ST_IDLE && s_next.st == ST_RUN) |=> ($countones(pump_run) <= 1))
    else $error("more than one pump at start");
  a_dead_drop: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_reg.st == ST_RUN) |=> ((pump_run & ~$past(alive_q)) == '0))
    else $error("failed unit kept running");
  a_event_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
    (ev != '0) |=> ((s_reg.irq_stat & $past(ev)) == $past(ev)))
    else $error("status event lost against clear");
endmodule : cascade_coordinator

// ### pump_peers.sv
// behavioural model of the other pump inverters on the shared link
`timescale 1ns/10ps
module pump_peers
  import cascade_pkg::*;
(
  // clock
  input wire logic core_clk,
  // commands from the bench
  input wire logic [7:0] health,
  input wire logic at_max_en,
  // run commands from the coordinator
  input wire logic [7:0] pump_run,
  // link view handed back
  output logic [7:0] peer_alive,
  output logic [7:0] peer_at_max
);
  import cascade_pkg::*;
  // a unit reports alive only while healthy; a failed unit goes silent
  assign peer_alive = health;
  // a running unit reaches max speed one cycle later, no auxiliary start delay
  always_ff @(posedge core_clk) begin
    peer_at_max <= at_max_en ? (pump_run & health) : 8'h00;
  end
endmodule : pump_peers

// ### test_cascade_coordinator.sv
// testbench of the pump group coordinator
`timescale 1ns/10ps
`define CHK(a, b) check_val(32'(a), 32'(b))
module test_cascade_coordinator;
  import cascade_pkg::*;
  localparam int SC = 20;
  logic core_clk;
  logic resetn;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] peer_alive;
  logic [7:0] peer_at_max;
  logic power_surplus;
  logic power_short;
  logic orig_master_back;
  logic [7:0] pump_run;
  logic link_active;
  logic param_copy;
  logic link_lost_alarm;
  logic address_conflict_alarm;
  logic [2:0] node_addr;
  logic irq;
  logic [7:0] health;
  logic at_max_en;
  logic [31:0] rd;
  int miscompares;
  int compares;
  time t0;
  // device under test with a short second
  cascade_coordinator #(.SEC_CYC(SC), .NP(8)) dut (
    .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .peer_alive(peer_alive), .peer_at_max(peer_at_max),
    .power_surplus(power_surplus), .power_short(power_short),
    .orig_master_back(orig_master_back), .pump_run(pump_run), .link_active(link_active),
    .param_copy(param_copy), .link_lost_alarm(link_lost_alarm),
    .address_conflict_alarm(address_conflict_alarm), .node_addr(node_addr), .irq(irq));
  // far side units
  pump_peers peers (.core_clk(core_clk), .health(health), .at_max_en(at_max_en),
    .pump_run(pump_run), .peer_alive(peer_alive), .peer_at_max(peer_at_max));
  // clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // compare and count
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  // verdict and end of run
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus_xfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus_xfer
  // control word from address and low flag bits
  function automatic logic [31:0] cw(input logic [2:0] a, input logic [7:0] b);
    return (32'(a) << CTRL_ADDR_LSB) | 32'(b);
  endfunction : cw
  // bounded wait on a condition
  `define WAITFOR(c, n) for (int k = 0; k < (n) && !(c); k++) @(posedge core_clk)
  // watchdog
  initial begin
    #(50 * 40000);
    miscompares++;
    test_done();
  end
  // main sequence
  initial begin
    resetn = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    power_surplus = 1'b0;
    power_short = 1'b0;
    orig_master_back = 1'b0;
    health = 8'hFF;
    at_max_en = 1'b0;
    miscompares = 0;
    compares = 0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    `CHK(pump_run, 8'h00);
    `CHK(link_active, 1'b1);
    `CHK(irq, 1'b0);
    // unmapped read, then enable register read back
    bus_xfer(1'b0, 6'h3C, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000);
    bus_xfer(1'b1, REG_PERIOD, 32'h0000_0000);
    bus_xfer(1'b1, REG_IRQ_EN, 32'h0000_0004);
    bus_xfer(1'b0, REG_IRQ_EN, 32'h0000_0000);
    `CHK(rd, 32'h0000_0004);
    // group start at the master: one pump first
    bus_xfer(1'b1, REG_IRQ_CLR, 32'h0000_000F);
    bus_xfer(1'b1, REG_CTRL, cw(3'h0, 8'h07));
    bus_xfer(1'b1, REG_CTRL, cw(3'h0, 8'h17) | 32'h0002_0000);
    repeat (3 * SC) @(posedge core_clk);
    `CHK($countones(pump_run), 1);
    // surplus with all at max adds pumps up to eight
    power_surplus <= 1'b1;
    at_max_en <= 1'b1;
    `WAITFOR(pump_run === 8'hFF, 20 * SC);
    `CHK(pump_run, 8'hFF);
    // a failed slave drops out, the rest keep running
    health <= 8'hF7;
    repeat (4 * SC) @(posedge core_clk);
    `CHK(pump_run[3], 1'b0);
    `CHK($countones(pump_run), 7);
    health <= 8'hFF;
    // period zero means a swap every five minutes
    bus_xfer(1'b1, REG_IRQ_CLR, 32'h0000_000F);
    repeat (SC) @(posedge core_clk);
    bus_xfer(1'b1, REG_IRQ_CLR, 32'h0000_000F);
    `WAITFOR(irq === 1'b1, 320 * SC);
    bus_xfer(1'b1, REG_IRQ_CLR, 32'h0000_000F);
    @(negedge core_clk);
    `CHK(irq, 1'b0);
    repeat (280 * SC) @(posedge core_clk);
    `CHK(irq, 1'b0);
    `WAITFOR(irq === 1'b1, 40 * SC);
    `CHK(irq, 1'b1);
    // two swaps skip excluded unit one: lead 0, 2, 3
    bus_xfer(1'b0, REG_STATUS, 32'h0000_0000);
    `CHK(rd[10:8], 3'h3);
    // falling power stops pumps one by one
    power_surplus <= 1'b0;
    power_short <= 1'b1;
    `WAITFOR($countones(pump_run) < 8, 10 * SC);
    `CHK($countones(pump_run), 7);
    `WAITFOR(pump_run === 8'h00, 20 * SC);
    `CHK(pump_run, 8'h00);
    power_short <= 1'b0;
    // open menu halts link; exit copies parameters
    bus_xfer(1'b1, REG_IRQ_EN, 32'h0000_0009);
    bus_xfer(1'b1, REG_IRQ_CLR, 32'h0000_000F);
    bus_xfer(1'b1, REG_CTRL, cw(3'h0, 8'h0F));
    repeat (5) @(posedge core_clk);
    `CHK(link_active, 1'b0);
    `CHK(link_lost_alarm, 1'b1);
    `CHK(irq, 1'b1);
    bus_xfer(1'b1, REG_IRQ_EN, 32'h0000_0000);
    @(negedge core_clk);
    `CHK(irq, 1'b0);
    bus_xfer(1'b1, REG_CTRL, cw(3'h0, 8'h07));
    `WAITFOR(param_copy === 1'b1, 20);
    `CHK(param_copy, 1'b1);
    repeat (3) @(posedge core_clk);
    `CHK(link_active, 1'b1);
    `CHK(link_lost_alarm, 1'b0);
    bus_xfer(1'b0, REG_IRQ_STAT, 32'h0000_0000);
    `CHK(rd & 32'h0000_0009, 32'h0000_0009);
    bus_xfer(1'b1, REG_IRQ_CLR, 32'h0000_000F);
    bus_xfer(1'b0, REG_IRQ_STAT, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000);
    // slave one takes over after the master is lost
    bus_xfer(1'b1, REG_CTRL, cw(3'h1, 8'h05));
    repeat (3) @(posedge core_clk);
    `CHK(node_addr, 3'h1);
    health <= 8'hFE;
    t0 = $time;
    repeat (2 * SC) @(posedge core_clk);
    `CHK(link_lost_alarm, 1'b1);
    `WAITFOR(node_addr === 3'h0, 40 * SC);
    `CHK(node_addr, 3'h0);
    `CHK(($time - t0) >= 28 * SC * 50, 1'b1);
    // original master returns: conflict, then roles restore
    health <= 8'hFF;
    orig_master_back <= 1'b1;
    t0 = $time;
    repeat (2 * SC) @(posedge core_clk);
    `CHK(address_conflict_alarm, 1'b1);
    `WAITFOR(node_addr === 3'h1, 40 * SC);
    `CHK(node_addr, 3'h1);
    `CHK(($time - t0) >= 28 * SC * 50, 1'b1);
    orig_master_back <= 1'b0;
    // no changeover without automatic restart
    bus_xfer(1'b1, REG_CTRL, cw(3'h1, 8'h01));
    health <= 8'hFE;
    repeat (40 * SC) @(posedge core_clk);
    `CHK(node_addr, 3'h1);
    health <= 8'hFF;
    repeat (2 * SC) @(posedge core_clk);
    // keypad activity aborts the changeover
    bus_xfer(1'b1, REG_CTRL, cw(3'h1, 8'h05));
    health <= 8'hFE;
    repeat (5 * SC) @(posedge core_clk);
    health <= 8'hFF;
    repeat (SC) @(posedge core_clk);
    `CHK(link_lost_alarm, 1'b1);
    bus_xfer(1'b1, REG_CTRL, cw(3'h1, 8'h45));
    repeat (40 * SC) @(posedge core_clk);
    `CHK(node_addr, 3'h1);
    test_done();
  end
endmodule : test_cascade_coordinator
